/* hdl/lssl_sync.sv */
// two-flop level synchroniser, per bit
module lssl_sync #(
    parameter int     W   = 1,
    parameter logic   RST = 1'b0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= {W{RST}};
            q      <= {W{RST}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // lssl_sync

/* hdl/lssl_top.sv */
// eight-channel led sink control: shift register, latch, mode and detect
//
// Operation
// - sinks follow latched bits while enable line low; all blanked when high
// - one-shift-clock low pulse on enable line enters the mode-switching phase
// - in detect mode low enable drives sinks and checks loads into shifter
// - last shift stage drives serial_out for daisy-chaining drivers
// - strobe line latches data except at the switching phase's select edge; there it selects
// - fault check and capture happen only in detect mode
// - strobe pulse at the switching phase's select edge leaves the output latch untouched
// - captured error bits shift out on serial_out with the shift clock
// - latch holds while strobe low; serial_out gives bit from seven clocks ago
// - shifter advances one place taking serial_in on each shift-clock rise except a fault load
// - latch follows shifter while strobe high except at the select edge, holds once it falls
// - in switching phase strobe high picks detect mode, low picks normal
module lssl_top
    import lssl_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 shift_clk,
    input  wire lssl_pkg::lssl_pins_t pins,
    input  wire logic [7:0]           channel_fault,
    output logic                      serial_out,
    output logic [7:0]                current_sink_channels,
    output logic                      detect_mode
);
    import lssl_pkg::*;

    // ---------------- shift-clock domain ----------------
    lssl_phase_t phase_r;
    lssl_phase_t phase_nxt;
    lssl_phase_t prev_mode_r;
    logic        en_prev_r;
    logic [7:0]  shift_r;
    logic [7:0]  shift_nxt;
    logic [7:0]  latch_r;
    logic        latch_tog_r;
    logic        detect_lvl_r;
    logic        err_valid_ls;

    // error word is read here only while its valid flag, crossed below,
    // says it is stable; it changes only when the valid flag is low
    logic [7:0]  err_word_r;
    logic        err_valid_r;

    wire logic en_line     = pins.enable_switch_detect_line;
    wire logic strobe      = pins.latch_strobe_mode_line;
    wire logic in_switch   = (phase_r == LSSL_SWITCH);
    // high-to-low seen at this edge: a candidate trigger
    wire logic trig_start  = !in_switch && !en_line && en_prev_r;
    // low period ended after more than one edge, in detect mode
    wire logic detect_end  = (phase_r == LSSL_DETECT) && en_line
                             && !en_prev_r && err_valid_ls;
    // only the select edge of a trigger is refused; a long low is a plain
    // enable, so its second edge must still strobe data
    wire logic strobe_data = strobe && !(in_switch && en_line);
    // mode holds through the switching phase, so a long low cannot flicker
    // it and the fault counter in the core domain is not restarted
    wire logic detect_nxt  = (phase_nxt == LSSL_SWITCH) ? detect_lvl_r
                             : (phase_nxt == LSSL_DETECT);

    always_comb begin
        phase_nxt = phase_r;
        unique case (phase_r)
            LSSL_NORMAL,
            LSSL_DETECT: begin
                if (trig_start) begin
                    phase_nxt = LSSL_SWITCH;
                end
            end
            LSSL_SWITCH: begin
                if (en_line) begin
                    // low spanned exactly one edge: take the selection
                    phase_nxt = strobe ? LSSL_DETECT : LSSL_NORMAL;
                end else begin
                    // longer low is a plain output enable
                    phase_nxt = prev_mode_r;
                end
            end
            default: phase_nxt = LSSL_NORMAL;
        endcase
    end

    // captured faults replace the shift for one edge, then shift out
    assign shift_nxt = detect_end ? err_word_r
                                  : {shift_r[6:0], pins.serial_in};

    always_ff @(posedge shift_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r     <= LSSL_NORMAL;
            prev_mode_r <= LSSL_NORMAL;
            en_prev_r   <= 1'b1;
        end else begin
            phase_r   <= phase_nxt;
            en_prev_r <= en_line;
            if (!in_switch) begin
                prev_mode_r <= phase_r;
            end
        end
    end

    always_ff @(posedge shift_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= SHIFT_RST;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    // latch is a registered copy taken at each edge with strobe_data high,
    // so it shows the bit just shifted in, as a transparent latch would
    always_ff @(posedge shift_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_r     <= LATCH_RST;
            latch_tog_r <= 1'b0;
        end else if (strobe_data) begin
            latch_r     <= shift_nxt;
            latch_tog_r <= ~latch_tog_r;
        end
    end

    always_ff @(posedge shift_clk or negedge rst_n) begin
        if (!rst_n) begin
            detect_lvl_r <= 1'b0;
        end else begin
            detect_lvl_r <= detect_nxt;
        end
    end

    // the last stage itself is the chain output: bit n-7 after n shifts
    assign serial_out  = shift_r[7];
    assign detect_mode = detect_lvl_r;

    lssl_sync #(
        .W   (1),
        .RST (1'b0)
    ) u_valid_ls (
        .clk   (shift_clk),
        .rst_n (rst_n),
        .d     (err_valid_r),
        .q     (err_valid_ls)
    );

    // ---------------- core clock domain ----------------
    logic                 en_s;
    logic                 detect_s;
    logic                 tog_s;
    logic [7:0]           fault_s;
    logic                 tog_d_r;
    logic                 en_d_r;
    logic [7:0]           latch_c_r;
    logic [7:0]           sink_r;
    logic [ERR_CNT_W-1:0] err_cnt_r;

    lssl_sync #(
        .W   (1),
        .RST (1'b1)
    ) u_en_s (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (en_line),
        .q     (en_s)
    );

    lssl_sync #(
        .W   (2),
        .RST (1'b0)
    ) u_ctl_s (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({detect_lvl_r, latch_tog_r}),
        .q     ({detect_s, tog_s})
    );

    lssl_sync #(
        .W   (8),
        .RST (1'b0)
    ) u_fault_s (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (channel_fault),
        .q     (fault_s)
    );

    // the shift clock is far slower than clk, so the latch word has long
    // settled by the time its toggle arrives through the synchroniser
    wire logic latch_new = tog_s ^ tog_d_r;
    wire logic en_fell   = en_d_r && !en_s;
    wire logic err_done  =
        (err_cnt_r == ERR_CNT_W'(ERR_SETUP_CYC - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_d_r   <= 1'b0;
            en_d_r    <= 1'b1;
            latch_c_r <= LATCH_RST;
        end else begin
            tog_d_r <= tog_s;
            en_d_r  <= en_s;
            if (latch_new) begin
                latch_c_r <= latch_r;
            end
        end
    end

    // blanking overrides the pattern in every phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sink_r <= 8'h00;
        end else begin
            sink_r <= en_s ? 8'h00 : latch_c_r;
        end
    end

    assign current_sink_channels = sink_r;

    // fault sampled only after the sinks have been on for the setup time;
    // a shorter enable yields no fresh word and the shifter just shifts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_cnt_r   <= '0;
            err_valid_r <= 1'b0;
            err_word_r  <= ERR_RST;
        end else if (en_s || !detect_s) begin
            err_cnt_r <= '0;
        end else if (en_fell) begin
            err_cnt_r   <= '0;
            err_valid_r <= 1'b0;
        end else if (!err_valid_r) begin
            if (err_done) begin
                err_word_r  <= fault_s;
                err_valid_r <= 1'b1;
            end else begin
                err_cnt_r <= err_cnt_r + 1'b1;
            end
        end
    end

endmodule // lssl_top

/* shared/lssl_pkg.sv */
// constants and types shared by the led sink shift/latch/detect logic
package lssl_pkg;

    localparam int CHAN_NUM           = 8;
    localparam int CLK_FREQ_MHZ       = 200;
    // least time the sinks must stay on before fault status is valid
    localparam int ERR_SETUP_NS       = 2000;
    localparam int ERR_SETUP_CYC      =
        (ERR_SETUP_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int ERR_CNT_W          = $clog2(ERR_SETUP_CYC + 1);

    localparam logic [7:0] SHIFT_RST  = 8'h00;
    localparam logic [7:0] LATCH_RST  = 8'h00;
    localparam logic [7:0] ERR_RST    = 8'h00;

    typedef enum logic [1:0] {
        LSSL_NORMAL = 2'b00,
        LSSL_SWITCH = 2'b01,
        LSSL_DETECT = 2'b10
    } lssl_phase_t;

    // controller-side pins, all sampled on the shift clock
    typedef struct packed {
        logic serial_in;
        logic latch_strobe_mode_line;
        logic enable_switch_detect_line;
    } lssl_pins_t;

endpackage

/* tb/lssl_chk.sv */
// port checker for the led sink control block
module lssl_chk
    import lssl_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 shift_clk,
    input wire lssl_pkg::lssl_pins_t pins,
    input wire logic [7:0]           channel_fault,
    input wire logic                 serial_out,
    input wire logic [7:0]           current_sink_channels,
    input wire logic                 detect_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic  en  = pins.enable_switch_detect_line;
    wire logic  stb = pins.latch_strobe_mode_line;
    logic [4:0] hi_r;
    logic [4:0] qt_r;
    logic [3:0] edge_cnt_r;
    // counts saturate so a long idle never wraps into a false window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_r <= 5'h00;
            qt_r <= 5'h00;
        end else begin
            hi_r <= en ? hi_r + 5'(hi_r != 5'h1F) : 5'h00;
            qt_r <= (en | stb) ? 5'h00 : qt_r + 5'(qt_r != 5'h1F);
        end
    end
    // shift-clock edges since reset, so no history is read before it
    always_ff @(posedge shift_clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_cnt_r <= 4'h0;
        end else begin
            edge_cnt_r <= edge_cnt_r + 4'(edge_cnt_r != 4'hF);
        end
    end
    a_serial_delay: assert property (
        @(posedge shift_clk) disable iff (!rst_n)
        (!detect_mode)[*8] ##1 (!detect_mode && edge_cnt_r == 4'hF)
        |-> serial_out == $past(pins.serial_in, 8)) else $error("bad delay");
    // a fault load needs a low edge just before it: ten high edges rule
    // out a load anywhere in the eight-edge window
    a_shift_enhigh: assert property (
        @(posedge shift_clk) disable iff (!rst_n)
        en ##1 en[*8] ##1 (en && edge_cnt_r == 4'hF)
        |-> serial_out == $past(pins.serial_in, 8)) else $error("bad shift");
    a_blank_high: assert property (
        @(posedge clk) disable iff (!rst_n)
        hi_r == 5'h1F |-> current_sink_channels == 8'h00)
        else $error("sinks on while enable high");
    a_sink_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        qt_r == 5'h1F |-> $stable(current_sink_channels))
        else $error("sinks moved without strobe");
    a_mode_enter: assert property (
        @(posedge shift_clk) disable iff (!rst_n)
        en ##1 !en ##1 en |=> detect_mode == $past(stb))
        else $error("mode not taken from strobe");
    a_mode_keep: assert property (
        @(posedge shift_clk) disable iff (!rst_n)
        en ##1 !en ##1 !en |=> $stable(detect_mode))
        else $error("long low changed mode");
    a_mode_cause: assert property (
        @(posedge shift_clk) disable iff (!rst_n)
        (edge_cnt_r == 4'hF) && $changed(detect_mode)
        |-> $past(en) && !$past(en, 2) && $past(en, 3))
        else $error("mode changed without trigger");
    a_reset_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> current_sink_channels == 8'h00)
        else $error("sinks on out of reset");
endmodule // lssl_chk

bind lssl_top lssl_chk u_chk (.clk, .rst_n, .shift_clk, .pins,
    .channel_fault, .serial_out, .current_sink_channels, .detect_mode);

/* tb/lssl_ctrl.sv */
// controller model driving data, strobe/mode and enable pins
module lssl_ctrl
    import lssl_pkg::*;
(
    input wire logic            shift_clk,
    output lssl_pkg::lssl_pins_t pins
);
    timeunit 1ns;
    timeprecision 100ps;
    initial pins = '{1'b0, 1'b0, 1'b1};
    // pins move just after an edge; the device takes them on the next one
    task automatic cyc(logic si, logic stb, logic en);
        @(posedge shift_clk);
        pins <= '{si, stb, en};
    endtask
    // msb first, strobe on the last bit
    task automatic send(logic [7:0] b, logic stb, logic en);
        for (int i = 7; i >= 0; i--) begin
            cyc(b[i], stb && i == 0, en);
        end
        cyc(~b[0], 1'b0, en);
    endtask
    // high, low for one edge, high with mode level
    task automatic trigger(logic sel);
        cyc(1'b1, 1'b0, 1'b1);
        cyc(1'b0, 1'b0, 1'b0);
        cyc(1'b1, sel, 1'b1);
        cyc(1'b0, 1'b0, 1'b1);
    endtask
endmodule // lssl_ctrl

/* tb/test_lssl_top.sv */
// self-checking bench for the led sink control block
module test_lssl_top;
    import lssl_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk;
    logic       rst_n;
    logic       shift_clk;
    lssl_pins_t pins;
    logic [7:0] channel_fault;
    logic       serial_out;
    logic [7:0] current_sink_channels;
    logic       detect_mode;
    logic [7:0] d;
    logic       sbit;
    logic [7:0] hist;
    int         n_mismatch;
    int         checks;
    lssl_ctrl ctrl (.shift_clk, .pins);
    lssl_top dut (.clk, .rst_n, .shift_clk, .pins, .channel_fault,
        .serial_out, .current_sink_channels, .detect_mode);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        shift_clk = 1'b0;
        #7.3;
        forever #32 shift_clk = ~shift_clk;
    end
    initial begin
        #200000;
        n_mismatch++;
        results();
    end
    function automatic logic [7:0] sinks_exp(logic [7:0] l, logic en);
        return en ? 8'h00 : l;
    endfunction
    task automatic check(logic [7:0] got, logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h want %h", $time, got, exp);
        end
    endtask
    // three edges cover the pin sample plus the sync into clk
    task automatic hold(logic en);
        repeat (3) ctrl.cyc(1'($urandom()), 1'b0, en);
        #1;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        channel_fault = 8'h00;
        n_mismatch = 0;
        checks = 0;
        void'($urandom(19986));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            d = (i < 2) ? {8{i[0]}} : 8'($urandom());
            ctrl.send(d, 1'b1, 1'b0);
            hold(1'b0);
            check(current_sink_channels, sinks_exp(d, 1'b0));
            ctrl.send(~d, 1'b0, 1'b0);
            hold(1'b0);
            check(current_sink_channels, sinks_exp(d, 1'b0));
            hold(1'b1);
            check(current_sink_channels, sinks_exp(d, 1'b1));
        end
        $display("normal test done");
        ctrl.trigger(1'b1);
        #1;
        check({7'h00, detect_mode}, 8'h01);
        hold(1'b0);
        check(current_sink_channels, d);
        for (int r = 0; r < 3; r++) begin
            d = (r == 0) ? 8'h81 : 8'($urandom());
            @(posedge clk) channel_fault <= d;
            // 40 edges keep the sinks on past the fault settle time
            repeat (40) ctrl.cyc(1'b0, 1'b0, 1'b0);
            ctrl.cyc(1'b0, 1'b0, 1'b1);
            for (int i = 7; i >= 0; i--) begin
                ctrl.cyc(1'b0, 1'b0, 1'b1);
                #1;
                check({7'h00, serial_out}, {7'h00, d[i]});
            end
        end
        $display("detect test done");
        ctrl.trigger(1'b0);
        #1;
        check({7'h00, detect_mode}, 8'h00);
        @(posedge clk) channel_fault <= 8'hFF;
        // faults must never reach the shifter outside detect mode, not
        // even at the edge where a long low enable ends
        hist = 8'h00;
        for (int j = 0; j < 52; j++) begin
            sbit = 1'($urandom());
            ctrl.cyc(sbit, 1'b0, (j >= 40));
            #1;
            if (j >= 8) begin
                check({7'h00, serial_out}, {7'h00, hist[7]});
            end
            hist = {hist[6:0], sbit};
        end
        $display("return test done");
        results();
    end
endmodule // test_lssl_top
